/* inc/ssf_consts.svh */
`ifndef SSF_CONSTS_SVH
`define SSF_CONSTS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SSF_OFS_STATUS      4'h0
`define SSF_OFS_CONTROL     4'h4
`define SSF_OFS_IRQ_STATUS  4'h8
`define SSF_OFS_IRQ_MASK    4'hC

// ****************************************
// status register bit positions
// ****************************************
`define SSF_BIT_FRAME_ERR   12
`define SSF_BIT_ACTIVITY    11
`define SSF_BIT_TX_UNDERRUN 8
`define SSF_BIT_SHIFT_EMPTY 7
`define SSF_BIT_RX_OVERFLOW 6
`define SSF_BIT_RX_EMPTY    5
`define SSF_BIT_TX_EMPTY    3
`define SSF_BIT_TX_FULL     1
`define SSF_BIT_RX_FULL     0

// ****************************************
// control register bit positions
// ****************************************
`define SSF_BIT_MODULE_EN   0
`define SSF_BIT_IGN_UNDERR  1
`define SSF_BIT_ENH_BUF     2

// ****************************************
// interrupt status bit positions
// ****************************************
`define SSF_IRQ_FRAME_ERR   0
`define SSF_IRQ_UNDERRUN    1
`define SSF_IRQ_OVERFLOW    2
`define SSF_IRQ_RX_READY    3
`define SSF_IRQ_WIDTH       4

// ****************************************
// reset values
// ****************************************
`define SSF_RST_CONTROL     3'h0
`define SSF_RST_IRQ         4'h0
`define SSF_ELM_ZERO        6'h00
`define SSF_RST_RDATA       32'h00000000
`define SSF_RST_RX_EMPTY    1'b1

`endif

/* inc/ssf_pkg.sv */
package ssf_pkg;

  typedef enum logic [1:0] {
    SSF_WB_IDLE = 2'b00,
    SSF_WB_ACK  = 2'b01
  } ssf_wb_state_t;

  typedef logic [15:0] ssf_status_t;

endpackage

/* inc/ssf_flag_if.sv */
`timescale 1ns/100ps

interface ssf_flag_if;
  logic clr_frame_err;
  logic clr_rx_overflow;
  logic frame_err;
  logic rx_overflow;
  logic tx_underrun;

  modport core (
    input  clr_frame_err,
    input  clr_rx_overflow,
    output frame_err,
    output rx_overflow,
    output tx_underrun
  );

  modport regs (
    output clr_frame_err,
    output clr_rx_overflow,
    input  frame_err,
    input  rx_overflow,
    input  tx_underrun
  );
endinterface

/* rtl/ssf_sticky_flags.sv */
`timescale 1ns/100ps
`include "ssf_consts.svh"

module ssf_sticky_flags (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // events from the port
  input  wire logic frame_error_evt,
  input  wire logic rx_overflow_evt,
  input  wire logic underrun_cond,
  // configuration
  input  wire logic module_enable,
  input  wire logic ignore_underrun,
  // flags and clears
  ssf_flag_if.core  flg
);

  logic frame_ff;
  logic nxt_frame;
  logic ovf_ff;
  logic nxt_ovf;
  logic tur_ff;
  logic nxt_tur;

  always_comb begin
    // set beats a clear in the same cycle
    nxt_frame = frame_error_evt | (frame_ff & ~flg.clr_frame_err);
    nxt_ovf   = rx_overflow_evt | (ovf_ff & ~flg.clr_rx_overflow);
    if (!module_enable) begin
      nxt_tur = 1'b0;
    end else if (ignore_underrun) begin
      nxt_tur = underrun_cond;
    end else begin
      nxt_tur = underrun_cond | tur_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frame_ff <= 1'b0;
      ovf_ff   <= 1'b0;
      tur_ff   <= 1'b0;
    end else begin
      frame_ff <= nxt_frame;
      ovf_ff   <= nxt_ovf;
      tur_ff   <= nxt_tur;
    end
  end

  assign flg.frame_err   = frame_ff;
  assign flg.rx_overflow = ovf_ff;
  assign flg.tx_underrun = tur_ff;

endmodule

/* rtl/ssf_status_top.sv */
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
`include "ssf_consts.svh"

// Functional notes
// - A detected framing error sets the frame error flag at bit 12, which holds until software clears it.
// - The activity flag at bit 11 reads one while any transfer is in progress and zero otherwise.
// - A transmit underrun sets the underrun flag at bit 8.
// - The underrun flag is held at zero while the module enable is zero.
// - With ignore-underrun set the underrun flag follows the live condition and needs no clear.
// - The shifter-empty flag at bit 7 is one only when neither transmit buffer nor shift register holds data.
// - A complete word received while the receive buffer is full sets the overflow flag at bit 6.
// - Frame error and overflow are set only by hardware and cleared by software; other flags are read-only.
// - In standard mode rx-empty at bit 5 sets on a data buffer read and clears on a shift-to-buffer move.
// - In enhanced mode rx-empty is one exactly when the six-bit element count is zero.
// - Status bits 15 to 13, 10 to 9 and 4 read as zero.

module ssf_status_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // port status inputs
  input  wire logic        frame_error_evt,
  input  wire logic        transfer_active,
  input  wire logic        underrun_cond,
  input  wire logic        tx_shift_busy,
  input  wire logic        rx_word_done,
  input  wire logic        data_buffer_read,
  input  wire logic        tx_buffer_full,
  input  wire logic        tx_buffer_empty,
  input  wire logic [5:0]  rx_element_count,
  input  wire logic        rx_buffer_full,
  // port configuration outputs
  output logic             module_enable,
  output logic             ignore_underrun,
  output logic             enhanced_mode,
  // interrupt
  output logic             irq
);

  // ****************************************
  // state
  // ****************************************
  ssf_pkg::ssf_wb_state_t wb_st_ff;
  ssf_pkg::ssf_wb_state_t nxt_wb_st;
  logic [31:0]            rdata_ff;
  logic [31:0]            nxt_rdata;
  logic [2:0]             ctrl_ff;
  logic [2:0]             nxt_ctrl;
  logic [3:0]             irq_st_ff;
  logic [3:0]             nxt_irq_st;
  logic [3:0]             irq_mask_ff;
  logic [3:0]             nxt_irq_mask;
  logic                   rx_empty_std_ff;
  logic                   nxt_rx_empty_std;
  logic                   irq_ff;
  logic                   nxt_irq;
  ssf_pkg::ssf_status_t   status;
  logic                   req;
  logic                   wr_lane0;
  logic                   rx_empty;
  logic                   rx_move;
  logic [3:0]             irq_evt;

  ssf_flag_if flg ();

  ssf_sticky_flags u_flags (
    .ref_clk         (ref_clk),
    .reset           (reset),
    .frame_error_evt (frame_error_evt),
    .rx_overflow_evt (rx_word_done & rx_buffer_full),
    .underrun_cond   (underrun_cond),
    .module_enable   (module_enable),
    .ignore_underrun (ignore_underrun),
    .flg             (flg.core)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic hit(input logic [3:0] adr, input logic [3:0] ofs);
    hit = (adr == ofs);
  endfunction

  assign req             = wb_cyc_i & wb_stb_i & (wb_st_ff == ssf_pkg::SSF_WB_IDLE);
  assign wr_lane0        = req & wb_we_i & wb_sel_i[0];
  assign module_enable   = ctrl_ff[`SSF_BIT_MODULE_EN];
  assign ignore_underrun = ctrl_ff[`SSF_BIT_IGN_UNDERR];
  assign enhanced_mode   = ctrl_ff[`SSF_BIT_ENH_BUF];
  assign rx_move         = rx_word_done & ~rx_buffer_full;

  // ****************************************
  // status word
  // ****************************************
  always_comb begin
    if (enhanced_mode) begin
      rx_empty = (rx_element_count == `SSF_ELM_ZERO);
    end else begin
      rx_empty = rx_empty_std_ff;
    end
    status                            = 16'h0000;
    status[`SSF_BIT_FRAME_ERR]        = flg.frame_err;
    status[`SSF_BIT_ACTIVITY]         = transfer_active;
    status[`SSF_BIT_TX_UNDERRUN]      = flg.tx_underrun;
    status[`SSF_BIT_SHIFT_EMPTY]      = tx_buffer_empty & ~tx_shift_busy;
    status[`SSF_BIT_RX_OVERFLOW]      = flg.rx_overflow;
    status[`SSF_BIT_RX_EMPTY]         = rx_empty;
    status[`SSF_BIT_TX_EMPTY]         = tx_buffer_empty;
    status[`SSF_BIT_TX_FULL]          = tx_buffer_full;
    status[`SSF_BIT_RX_FULL]          = rx_buffer_full;
  end

  // ****************************************
  // software clears of sticky flags
  // ****************************************
  always_comb begin
    flg.clr_frame_err   = 1'b0;
    flg.clr_rx_overflow = 1'b0;
    if (req && wb_we_i && hit(wb_adr_i, `SSF_OFS_STATUS)) begin
      // write one to clear; only these two flags are clearable
      flg.clr_frame_err   = wb_sel_i[1] & wb_dat_i[`SSF_BIT_FRAME_ERR];
      flg.clr_rx_overflow = wb_sel_i[0] & wb_dat_i[`SSF_BIT_RX_OVERFLOW];
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_wb_st        = ssf_pkg::SSF_WB_IDLE;
    nxt_rdata        = rdata_ff;
    nxt_ctrl         = ctrl_ff;
    nxt_irq_mask     = irq_mask_ff;
    nxt_rx_empty_std = rx_empty_std_ff;

    case (wb_st_ff)
      ssf_pkg::SSF_WB_IDLE: begin
        if (req) begin
          nxt_wb_st = ssf_pkg::SSF_WB_ACK;
        end
      end
      ssf_pkg::SSF_WB_ACK: begin
        nxt_wb_st = ssf_pkg::SSF_WB_IDLE;
      end
      default: begin
        nxt_wb_st = ssf_pkg::SSF_WB_IDLE;
      end
    endcase

    if (req && !wb_we_i) begin
      if (hit(wb_adr_i, `SSF_OFS_STATUS)) begin
        nxt_rdata = {16'h0000, status};
      end else if (hit(wb_adr_i, `SSF_OFS_CONTROL)) begin
        nxt_rdata = {29'h0000000, ctrl_ff};
      end else if (hit(wb_adr_i, `SSF_OFS_IRQ_STATUS)) begin
        nxt_rdata = {28'h0000000, irq_st_ff};
      end else if (hit(wb_adr_i, `SSF_OFS_IRQ_MASK)) begin
        nxt_rdata = {28'h0000000, irq_mask_ff};
      end else begin
        nxt_rdata = 32'h00000000;
      end
    end

    if (wr_lane0 && hit(wb_adr_i, `SSF_OFS_CONTROL)) begin
      nxt_ctrl = wb_dat_i[2:0];
    end
    if (wr_lane0 && hit(wb_adr_i, `SSF_OFS_IRQ_MASK)) begin
      nxt_irq_mask = wb_dat_i[3:0];
    end

    // move into buffer wins over a simultaneous read
    if (rx_move) begin
      nxt_rx_empty_std = 1'b0;
    end else if (data_buffer_read) begin
      nxt_rx_empty_std = 1'b1;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  always_comb begin
    irq_evt                     = 4'h0;
    irq_evt[`SSF_IRQ_FRAME_ERR] = frame_error_evt;
    irq_evt[`SSF_IRQ_UNDERRUN]  = underrun_cond & module_enable;
    irq_evt[`SSF_IRQ_OVERFLOW]  = rx_word_done & rx_buffer_full;
    irq_evt[`SSF_IRQ_RX_READY]  = rx_move;
    nxt_irq_st = irq_st_ff;
    if (wr_lane0 && hit(wb_adr_i, `SSF_OFS_IRQ_STATUS)) begin
      nxt_irq_st = irq_st_ff & ~wb_dat_i[3:0];
    end
    nxt_irq_st = nxt_irq_st | irq_evt;
    nxt_irq    = |(nxt_irq_st & nxt_irq_mask);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wb_st_ff        <= ssf_pkg::SSF_WB_IDLE;
      rdata_ff        <= `SSF_RST_RDATA;
      ctrl_ff         <= `SSF_RST_CONTROL;
      irq_st_ff       <= `SSF_RST_IRQ;
      irq_mask_ff     <= `SSF_RST_IRQ;
      rx_empty_std_ff <= `SSF_RST_RX_EMPTY;
      irq_ff          <= 1'b0;
    end else begin
      wb_st_ff        <= nxt_wb_st;
      rdata_ff        <= nxt_rdata;
      ctrl_ff         <= nxt_ctrl;
      irq_st_ff       <= nxt_irq_st;
      irq_mask_ff     <= nxt_irq_mask;
      rx_empty_std_ff <= nxt_rx_empty_std;
      irq_ff          <= nxt_irq;
    end
  end

  assign wb_ack_o = (wb_st_ff == ssf_pkg::SSF_WB_ACK);
  assign wb_dat_o = rdata_ff;
  assign irq      = irq_ff;

endmodule

/* verification/ssf_far_model.sv */
`timescale 1ns/100ps

module ssf_far_model (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // frame request
  input  wire logic go,
  input  wire logic bad,
  // events to the block
  output logic      transfer_active,
  output logic      rx_word_done,
  output logic      frame_error_evt
);
  // ****************
  // frame sequencer
  // ****************
  logic [3:0] cnt_ff;
  logic       bad_ff;

  always_ff @(posedge ref_clk) begin
    cnt_ff <= reset ? 4'h0 : go ? 4'h8 : cnt_ff - {3'h0, cnt_ff != 4'h0};
    bad_ff <= go ? bad : bad_ff;
  end

  assign transfer_active = cnt_ff != 4'h0;
  assign rx_word_done    = cnt_ff == 4'h1 && !bad_ff;
  assign frame_error_evt = cnt_ff == 4'h1 && bad_ff;
endmodule

/* verification/ssf_status_monitor.sv */
`timescale 1ns/100ps

module ssf_status_monitor (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // port status and config
  input wire logic        transfer_active,
  input wire logic        underrun_cond,
  input wire logic        tx_shift_busy,
  input wire logic        tx_buffer_full,
  input wire logic        tx_buffer_empty,
  input wire logic [5:0]  rx_element_count,
  input wire logic        rx_buffer_full,
  input wire logic        module_enable,
  input wire logic        ignore_underrun,
  input wire logic        enhanced_mode
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire rd_st = wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
  wire ign   = module_enable && ignore_underrun;

  property p_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_take: assert property (p_take) else $error("no ack");
  property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("long ack");
  property p_busy; rd_st |-> wb_dat_o[11] == $past(transfer_active); endproperty
  a_busy: assert property (p_busy) else $error("activity bit");
  property p_rsvd; rd_st |-> wb_dat_o[15:13] == 3'h0 && wb_dat_o[10:9] == 2'h0 && !wb_dat_o[4]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits");
  property p_shift_empty; rd_st |-> wb_dat_o[7] == $past(tx_buffer_empty && !tx_shift_busy); endproperty
  a_shift_empty: assert property (p_shift_empty) else $error("shifter empty");
  property p_occ;
    rd_st |-> {wb_dat_o[3], wb_dat_o[1:0]} == $past({tx_buffer_empty, tx_buffer_full, rx_buffer_full});
  endproperty
  a_occ: assert property (p_occ) else $error("occupancy");
  property p_enh; rd_st && $past(enhanced_mode) |-> wb_dat_o[5] == ($past(rx_element_count) == 6'h00); endproperty
  a_enh: assert property (p_enh) else $error("enhanced empty");
  property p_off; rd_st && !$past(module_enable) && !$past(module_enable, 2) |-> !wb_dat_o[8]; endproperty
  a_off: assert property (p_off) else $error("underrun off");
  property p_ign;
    rd_st && $past(ign) && $past(ign, 2) && $past(underrun_cond) == $past(underrun_cond, 2)
      |-> wb_dat_o[8] == $past(underrun_cond);
  endproperty
  a_ign: assert property (p_ign) else $error("live underrun");

  c_busy: cover property (rd_st && wb_dat_o[11]);
  c_ovf: cover property (rd_st && wb_dat_o[6]);
  c_tur: cover property (rd_st && wb_dat_o[8]);
endmodule

bind ssf_status_top ssf_status_monitor u_ssf_status_monitor (.ref_clk(ref_clk), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .transfer_active(transfer_active), .underrun_cond(underrun_cond),
  .tx_shift_busy(tx_shift_busy), .tx_buffer_full(tx_buffer_full), .tx_buffer_empty(tx_buffer_empty),
  .rx_element_count(rx_element_count), .rx_buffer_full(rx_buffer_full), .module_enable(module_enable),
  .ignore_underrun(ignore_underrun), .enhanced_mode(enhanced_mode));

/* verification/spi_status_flags_tb.sv */
`timescale 1ns/100ps

module spi_status_flags_tb;
  // ****************
  // stimulus and results
  // ****************
  logic        ref_clk, reset, cyc, stb, we, und, shb, dbr, tf, te, rf, go, bad;
  logic        fe, act, rwd, ack, me, iu, em, irq;
  logic [3:0]  adr;
  logic [5:0]  elm;
  logic [31:0] dat, q, q_o;
  int          n_mismatch, cmp_count;
  // {shift busy, tx full, tx empty, rx full}, status word
  logic [19:0] rows [4] = '{{4'hD, 16'h0023}, {4'h2, 16'h00A8}, {4'h3, 16'h00A9}, {4'hA, 16'h0028}};

  ssf_status_top u_ssf_status_top (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(q_o), .wb_ack_o(ack),
    .frame_error_evt(fe), .transfer_active(act), .underrun_cond(und), .tx_shift_busy(shb),
    .rx_word_done(rwd), .data_buffer_read(dbr), .tx_buffer_full(tf), .tx_buffer_empty(te),
    .rx_element_count(elm), .rx_buffer_full(rf), .module_enable(me), .ignore_underrun(iu),
    .enhanced_mode(em), .irq(irq));
  ssf_far_model u_ssf_far_model (.ref_clk(ref_clk), .reset(reset), .go(go), .bad(bad),
    .transfer_active(act), .rx_word_done(rwd), .frame_error_evt(fe));

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    q = q_o;
    {cyc, stb} <= 2'h0;
  endtask
  task automatic rd(input logic [3:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask
  task automatic frame(input logic b);
    @(posedge ref_clk);
    {go, bad} <= {1'b1, b};
    @(posedge ref_clk);
    go <= 1'b0;
  endtask
  task automatic note(input int t);
    $display("test %0d done", t);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #40000;
    n_mismatch++;
    end_sim;
  end

  initial begin
    {reset, cyc, stb, we, und, shb, dbr, tf, te, rf, go, bad} = 12'h808;
    {adr, dat, elm, n_mismatch, cmp_count} = '0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    rd(4'h0); chk("status", 16'h00A8, q[15:0]);
    rd(4'h4); chk("control", 16'h0, q[15:0]);
    rd(4'h2); chk("unmapped", 16'h0, q[15:0]);
    note(0);
    foreach (rows[i]) begin
      {shb, tf, te, rf} <= rows[i][19:16];
      rd(4'h0); chk("status", rows[i][15:0], q[15:0]);
    end
    note(1);
    {shb, tf, te, rf} <= 4'h2;
    frame(1'b0);
    rd(4'h0); chk("busy", 16'h1, q[11]);
    repeat (10) @(posedge ref_clk);
    rd(4'h0); chk("status", 16'h0088, q[15:0]);
    rf <= 1'b1;
    frame(1'b0);
    repeat (10) @(posedge ref_clk);
    rd(4'h0); chk("status", 16'h00C9, q[15:0]);
    wb(1'b1, 4'h0, 32'h0FFF);
    rd(4'h0); chk("status", 16'h0089, q[15:0]);
    dbr <= 1'b1;
    @(posedge ref_clk);
    dbr <= 1'b0;
    rd(4'h0); chk("status", 16'h00A9, q[15:0]);
    note(2);
    wb(1'b1, 4'h8, 32'hF);
    frame(1'b1);
    repeat (10) @(posedge ref_clk);
    chk("irq", 16'h0, irq);
    rd(4'h0); chk("frame err", 16'h1, q[12]);
    wb(1'b1, 4'hC, 32'h1);
    rd(4'h8); chk("irq status", 16'h1, q[0]);
    chk("irq", 16'h1, irq);
    wb(1'b1, 4'h0, 32'h1000);
    wb(1'b1, 4'h8, 32'h1);
    rd(4'h0); chk("frame err", 16'h0, q[12]);
    chk("irq", 16'h0, irq);
    note(3);
    wb(1'b1, 4'h4, 32'h1);
    und <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(4'h0); chk("underrun", 16'h1, q[8]);
    und <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(4'h0); chk("underrun", 16'h1, q[8]);
    wb(1'b1, 4'h4, 32'h0);
    rd(4'h0); chk("underrun", 16'h0, q[8]);
    wb(1'b1, 4'h4, 32'h3);
    chk("config", 16'h3, {em, iu, me});
    und <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(4'h0); chk("underrun", 16'h1, q[8]);
    und <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(4'h0); chk("underrun", 16'h0, q[8]);
    note(4);
    wb(1'b1, 4'h4, 32'h4);
    chk("config", 16'h4, {em, iu, me});
    rd(4'h0); chk("rx empty", 16'h1, q[5]);
    elm <= 6'h20;
    rd(4'h0); chk("rx empty", 16'h0, q[5]);
    note(5);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd(4'h4); chk("control", 16'h0, q[15:0]);
    note(6);
    end_sim;
  end
endmodule
